/* src/usb_gpio_pkg.sv */
package usb_gpio_pkg;

   // Register offsets
   localparam logic [7:0] OFS_P0_DATA      = 8'h00;
   localparam logic [7:0] OFS_P1_DATA      = 8'h01;
   localparam logic [7:0] OFS_P2_STATE     = 8'h02;
   localparam logic [7:0] OFS_P0_IRQ_EN    = 8'h04;
   localparam logic [7:0] OFS_P1_IRQ_EN    = 8'h05;
   localparam logic [7:0] OFS_P0_IRQ_POL   = 8'h06;
   localparam logic [7:0] OFS_P1_IRQ_POL   = 8'h07;
   localparam logic [7:0] OFS_P0_MODE_LO   = 8'h0A;
   localparam logic [7:0] OFS_P0_MODE_HI   = 8'h0B;
   localparam logic [7:0] OFS_P1_MODE_LO   = 8'h0C;
   localparam logic [7:0] OFS_P1_MODE_HI   = 8'h0D;
   localparam logic [7:0] OFS_DEV_ADDR     = 8'h10;
   localparam logic [7:0] OFS_CTRL_COUNT   = 8'h11;
   localparam logic [7:0] OFS_CTRL_MODE    = 8'h12;
   localparam logic [7:0] OFS_SEC_COUNT    = 8'h13;
   localparam logic [7:0] OFS_SEC_MODE     = 8'h14;
   localparam logic [7:0] OFS_BUS_STAT     = 8'h1F;
   localparam logic [7:0] OFS_GLOBAL_EN    = 8'h20;
   localparam logic [7:0] OFS_PIPE_EN      = 8'h21;
   localparam logic [7:0] OFS_TIMER_LO     = 8'h24;
   localparam logic [7:0] OFS_TIMER_HI     = 8'h25;
   localparam logic [7:0] OFS_EVT_STATUS   = 8'h30;
   localparam logic [7:0] OFS_EVT_MASK     = 8'h31;
   localparam logic [7:0] OFS_CLOCK_SETUP  = 8'hF8;
   localparam logic [7:0] OFS_PROC_STAT    = 8'hFF;

   // Implemented-bit masks; other bits read zero and ignore writes, except processor status bits 7 and 2, which read pending and sense
   localparam logic [7:0] MASK_FULL        = 8'hFF;
   localparam logic [7:0] MASK_TWO_PIN     = 8'h03;
   localparam logic [7:0] MASK_P2_STATE    = 8'h37;
   localparam logic [7:0] MASK_SEC_MODE    = 8'h9F;
   localparam logic [7:0] MASK_COUNT       = 8'hCF;
   localparam logic [7:0] MASK_BUS_STAT    = 8'hEF;
   localparam logic [7:0] MASK_GLOBAL_EN   = 8'hC7;
   localparam logic [7:0] MASK_TIMER_HI    = 8'h0F;
   localparam logic [7:0] MASK_EVT         = 8'h1F;
   localparam logic [7:0] MASK_PROC_WR     = 8'h79;

   // Field positions
   localparam int BUS_ACT_BIT  = 3;
   localparam int PS_PEND_BIT  = 7;
   localparam int PS_WDOG_BIT  = 6;
   localparam int PS_BUSEV_BIT = 5;
   localparam int PS_DROP_BIT  = 4;
   localparam int PS_SUSP_BIT  = 3;
   localparam int PS_SENSE_BIT = 2;
   localparam int PS_RUN_BIT   = 0;
   localparam int EV_P0_BIT    = 0;
   localparam int EV_P1_BIT    = 1;
   localparam int EV_T128_BIT  = 2;
   localparam int EV_T1024_BIT = 3;
   localparam int EV_BUS_BIT   = 4;

   // Reset values
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_PROC_STAT = 8'h01;

   // Timer: 12-bit count of microseconds
   localparam int TIMER_W       = 12;
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS       = 1000;
   localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T128_BIT      = 7;
   localparam int T1024_BIT     = 10;

   localparam int PIN_W = 15;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic       dplus;
      logic       serial_program_data;
      logic [2:0] p2;
      logic [1:0] p1;
      logic [7:0] p0;
   } pin_in_t;

   typedef struct packed {
      logic [7:0] p0_data;
      logic [1:0] p1_data;
      logic [7:0] p0_mode_lo;
      logic [7:0] p0_mode_hi;
      logic [1:0] p1_mode_lo;
      logic [1:0] p1_mode_hi;
   } pin_cfg_t;

endpackage : usb_gpio_pkg

/* src/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : pin_sync

/* src/free_timer.sv */
`timescale 1ns/10ps
module free_timer (
   input  wire logic                               ref_clk,
   input  wire logic                               rst_b,
   output logic [usb_gpio_pkg::TIMER_W-1:0]        count_q,
   output logic                                    tick128,
   output logic                                    tick1024
);

   logic [7:0] pre_q;
   logic       step;

   assign step = (pre_q == 8'(usb_gpio_pkg::TICK_CYCLES - 1));

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= step ? 8'h00 : pre_q + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= '0;
      end else if (step) begin
         count_q <= count_q + 1'b1;
      end
   end

   // One pulse each time the 128 us or 1.024 ms bit of the count rolls over
   assign tick128  = step && (&count_q[usb_gpio_pkg::T128_BIT-1:0]);
   assign tick1024 = step && (&count_q[usb_gpio_pkg::T1024_BIT-1:0]);

endmodule : free_timer

/* src/usb_gpio_register_map.sv */
// Overview of operation
// - Port zero pin interrupt enables, eight bits, write only, reset zero.
// - Port one interrupt enables, two low bits only, reset zero.
// - Port zero interrupt polarity, eight bits, write only, reset zero.
// - Port one interrupt polarity, two low bits only, reset zero.
// - Bus status/control: pull-up, regulator, irq mode, activity, line forcing.
// - Processor status: pending, watchdog, bus event, drop reset, suspend, sense, run.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module usb_gpio_register_map (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire usb_gpio_pkg::reg_req_t req,
   output logic [7:0]                  rdata_q,
   input  wire usb_gpio_pkg::pin_in_t  pins,
   output usb_gpio_pkg::pin_cfg_t      pin_cfg,
   output logic [7:0]                  dev_addr_q,
   output logic [7:0]                  bus_ctrl_q,
   input  wire logic                   bus_activity_evt,
   input  wire logic                   watchdog_evt,
   input  wire logic                   supply_drop_reset_evt,
   input  wire logic                   bus_irq_evt,
   input  wire logic                   irq_enable_sense,
   output logic [7:0]                  clock_setup_q,
   output logic [7:0]                  global_en_q,
   output logic [7:0]                  pipe_en_q,
   output logic                        suspend,
   output logic                        run,
   output logic                        irq
);

   logic [7:0] p0_data_q;
   logic [7:0] p1_data_q;
   logic [7:0] p0_en_q;
   logic [7:0] p1_en_q;
   logic [7:0] p0_pol_q;
   logic [7:0] p1_pol_q;
   logic [7:0] p0_mlo_q;
   logic [7:0] p0_mhi_q;
   logic [7:0] p1_mlo_q;
   logic [7:0] p1_mhi_q;
   logic [7:0] ctrl_cnt_q;
   logic [7:0] ctrl_mode_q;
   logic [7:0] sec_cnt_q;
   logic [7:0] sec_mode_q;
   logic [7:0] proc_q;
   logic [7:0] evt_status_q;
   logic [7:0] evt_mask_q;
   logic [7:0] events;
   logic [7:0] proc_view;
   logic [7:0] rd_mux;
   logic [7:0] p2_view;
   logic [usb_gpio_pkg::TIMER_W-1:0] timer_count;
   logic       tick128;
   logic       tick1024;
   logic [usb_gpio_pkg::PIN_W-1:0] pins_sync;
   usb_gpio_pkg::pin_in_t pin_now;
   logic [9:0] pin_prev_q;
   logic [9:0] pin_hit;
   logic [9:0] pin_en;
   logic [9:0] pin_pol;

   function automatic logic wr_at(input logic [7:0] ofs);
      wr_at = req.wr && (req.addr == ofs);
   endfunction : wr_at

   pin_sync #(
      .WIDTH   (usb_gpio_pkg::PIN_W)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .async_in(pins),
      .sync_out(pins_sync)
   );

   free_timer u_free_timer (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .count_q (timer_count),
      .tick128 (tick128),
      .tick1024(tick1024)
   );

   assign pin_now = pins_sync;

   // Port data and drive mode latches
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         p0_data_q <= usb_gpio_pkg::RST_ZERO;
         p1_data_q <= usb_gpio_pkg::RST_ZERO;
         p0_mlo_q  <= usb_gpio_pkg::RST_ZERO;
         p0_mhi_q  <= usb_gpio_pkg::RST_ZERO;
         p1_mlo_q  <= usb_gpio_pkg::RST_ZERO;
         p1_mhi_q  <= usb_gpio_pkg::RST_ZERO;
      end else begin
         if (wr_at(usb_gpio_pkg::OFS_P0_DATA)) begin
            p0_data_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_P1_DATA)) begin
            p1_data_q <= req.wdata & usb_gpio_pkg::MASK_TWO_PIN;
         end
         if (wr_at(usb_gpio_pkg::OFS_P0_MODE_LO)) begin
            p0_mlo_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_P0_MODE_HI)) begin
            p0_mhi_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_P1_MODE_LO)) begin
            p1_mlo_q <= req.wdata & usb_gpio_pkg::MASK_TWO_PIN;
         end
         if (wr_at(usb_gpio_pkg::OFS_P1_MODE_HI)) begin
            p1_mhi_q <= req.wdata & usb_gpio_pkg::MASK_TWO_PIN;
         end
      end
   end

   // Pin interrupt enables and polarities
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         p0_en_q  <= usb_gpio_pkg::RST_ZERO;
         p1_en_q  <= usb_gpio_pkg::RST_ZERO;
         p0_pol_q <= usb_gpio_pkg::RST_ZERO;
         p1_pol_q <= usb_gpio_pkg::RST_ZERO;
      end else begin
         if (wr_at(usb_gpio_pkg::OFS_P0_IRQ_EN)) begin
            p0_en_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_P1_IRQ_EN)) begin
            p1_en_q <= req.wdata & usb_gpio_pkg::MASK_TWO_PIN;
         end
         if (wr_at(usb_gpio_pkg::OFS_P0_IRQ_POL)) begin
            p0_pol_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_P1_IRQ_POL)) begin
            p1_pol_q <= req.wdata & usb_gpio_pkg::MASK_TWO_PIN;
         end
      end
   end

   // Polarity one catches a rising edge, zero a falling edge
   assign pin_en  = {p1_en_q[1:0], p0_en_q};
   assign pin_pol = {p1_pol_q[1:0], p0_pol_q};

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_prev_q <= 10'h000;
      end else begin
         pin_prev_q <= {pin_now.p1, pin_now.p0};
      end
   end

   for (genvar i = 0; i < 10; i++) begin : g_pin_edge
      logic cur;
      assign cur = (i < 8) ? pin_now.p0[i % 8] : pin_now.p1[i % 2];
      assign pin_hit[i] = pin_en[i] && (cur != pin_prev_q[i]) && (cur == pin_pol[i]);
   end

   // Device address, pipe counts and modes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dev_addr_q  <= usb_gpio_pkg::RST_ZERO;
         ctrl_cnt_q  <= usb_gpio_pkg::RST_ZERO;
         ctrl_mode_q <= usb_gpio_pkg::RST_ZERO;
         sec_cnt_q   <= usb_gpio_pkg::RST_ZERO;
         sec_mode_q  <= usb_gpio_pkg::RST_ZERO;
      end else begin
         if (wr_at(usb_gpio_pkg::OFS_DEV_ADDR)) begin
            dev_addr_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_CTRL_COUNT)) begin
            ctrl_cnt_q <= req.wdata & usb_gpio_pkg::MASK_COUNT;
         end
         if (wr_at(usb_gpio_pkg::OFS_CTRL_MODE)) begin
            ctrl_mode_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_SEC_COUNT)) begin
            sec_cnt_q <= req.wdata & usb_gpio_pkg::MASK_COUNT;
         end
         if (wr_at(usb_gpio_pkg::OFS_SEC_MODE)) begin
            sec_mode_q <= req.wdata & usb_gpio_pkg::MASK_SEC_MODE;
         end
      end
   end

   // Bus status and control; activity is set by the bus side, set beats clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_ctrl_q <= usb_gpio_pkg::RST_ZERO;
      end else begin
         if (wr_at(usb_gpio_pkg::OFS_BUS_STAT)) begin
            bus_ctrl_q <= req.wdata & usb_gpio_pkg::MASK_BUS_STAT;
         end
         if (bus_activity_evt) begin
            bus_ctrl_q[usb_gpio_pkg::BUS_ACT_BIT] <= 1'b1;
         end
      end
   end

   // Clock setup and interrupt enables
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         clock_setup_q <= usb_gpio_pkg::RST_ZERO;
         global_en_q   <= usb_gpio_pkg::RST_ZERO;
         pipe_en_q     <= usb_gpio_pkg::RST_ZERO;
      end else begin
         if (wr_at(usb_gpio_pkg::OFS_CLOCK_SETUP)) begin
            clock_setup_q <= req.wdata;
         end
         if (wr_at(usb_gpio_pkg::OFS_GLOBAL_EN)) begin
            global_en_q <= req.wdata & usb_gpio_pkg::MASK_GLOBAL_EN;
         end
         if (wr_at(usb_gpio_pkg::OFS_PIPE_EN)) begin
            pipe_en_q <= req.wdata & usb_gpio_pkg::MASK_TWO_PIN;
         end
      end
   end

   // Processor status: flags written by firmware, set by their events
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         proc_q <= usb_gpio_pkg::RST_PROC_STAT;
      end else begin
         if (wr_at(usb_gpio_pkg::OFS_PROC_STAT)) begin
            proc_q <= req.wdata & usb_gpio_pkg::MASK_PROC_WR;
         end
         if (watchdog_evt) begin
            proc_q[usb_gpio_pkg::PS_WDOG_BIT] <= 1'b1;
         end
         if (bus_irq_evt) begin
            proc_q[usb_gpio_pkg::PS_BUSEV_BIT] <= 1'b1;
         end
         if (supply_drop_reset_evt) begin
            proc_q[usb_gpio_pkg::PS_DROP_BIT] <= 1'b1;
         end
      end
   end

   always_comb begin
      proc_view = proc_q;
      proc_view[usb_gpio_pkg::PS_PEND_BIT]  = irq;
      proc_view[usb_gpio_pkg::PS_SENSE_BIT] = irq_enable_sense;
   end

   assign suspend = proc_q[usb_gpio_pkg::PS_SUSP_BIT];
   assign run     = proc_q[usb_gpio_pkg::PS_RUN_BIT];

   // Sticky event status, write one to clear, set wins over clear
   always_comb begin
      events = 8'h00;
      events[usb_gpio_pkg::EV_P0_BIT]    = |pin_hit[7:0];
      events[usb_gpio_pkg::EV_P1_BIT]    = |pin_hit[9:8];
      events[usb_gpio_pkg::EV_T128_BIT]  = tick128;
      events[usb_gpio_pkg::EV_T1024_BIT] = tick1024;
      events[usb_gpio_pkg::EV_BUS_BIT]   = bus_activity_evt;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         evt_status_q <= usb_gpio_pkg::RST_ZERO;
      end else if (wr_at(usb_gpio_pkg::OFS_EVT_STATUS)) begin
         evt_status_q <= (evt_status_q & ~req.wdata) | events;
      end else begin
         evt_status_q <= evt_status_q | events;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         evt_mask_q <= usb_gpio_pkg::RST_ZERO;
      end else if (wr_at(usb_gpio_pkg::OFS_EVT_MASK)) begin
         evt_mask_q <= req.wdata & usb_gpio_pkg::MASK_EVT;
      end
   end

   assign irq = |(evt_status_q & evt_mask_q);

   assign p2_view = {2'b00, pin_now.dplus, pin_now.serial_program_data, 1'b0, pin_now.p2};

   // Read mux; write-only and unmapped offsets read zero
   always_comb begin
      unique case (req.addr)
         usb_gpio_pkg::OFS_P0_DATA:     rd_mux = pin_now.p0;
         usb_gpio_pkg::OFS_P1_DATA:     rd_mux = {6'h00, pin_now.p1};
         usb_gpio_pkg::OFS_P2_STATE:    rd_mux = p2_view & usb_gpio_pkg::MASK_P2_STATE;
         usb_gpio_pkg::OFS_DEV_ADDR:    rd_mux = dev_addr_q;
         usb_gpio_pkg::OFS_CTRL_COUNT:  rd_mux = ctrl_cnt_q;
         usb_gpio_pkg::OFS_CTRL_MODE:   rd_mux = ctrl_mode_q;
         usb_gpio_pkg::OFS_SEC_COUNT:   rd_mux = sec_cnt_q;
         usb_gpio_pkg::OFS_SEC_MODE:    rd_mux = sec_mode_q;
         usb_gpio_pkg::OFS_BUS_STAT:    rd_mux = bus_ctrl_q;
         usb_gpio_pkg::OFS_GLOBAL_EN:   rd_mux = global_en_q;
         usb_gpio_pkg::OFS_PIPE_EN:     rd_mux = pipe_en_q;
         usb_gpio_pkg::OFS_TIMER_LO:    rd_mux = timer_count[7:0];
         usb_gpio_pkg::OFS_TIMER_HI:    rd_mux = {4'h0, timer_count[11:8]};
         usb_gpio_pkg::OFS_EVT_STATUS:  rd_mux = evt_status_q;
         usb_gpio_pkg::OFS_EVT_MASK:    rd_mux = evt_mask_q;
         usb_gpio_pkg::OFS_CLOCK_SETUP: rd_mux = clock_setup_q;
         usb_gpio_pkg::OFS_PROC_STAT:   rd_mux = proc_view;
         default:                       rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= req.rd ? rd_mux : 8'h00;
      end
   end

   assign pin_cfg.p0_data    = p0_data_q;
   assign pin_cfg.p1_data    = p1_data_q[1:0];
   assign pin_cfg.p0_mode_lo = p0_mlo_q;
   assign pin_cfg.p0_mode_hi = p0_mhi_q;
   assign pin_cfg.p1_mode_lo = p1_mlo_q[1:0];
   assign pin_cfg.p1_mode_hi = p1_mhi_q[1:0];

   // Checks
   chk_p0_en_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_at(usb_gpio_pkg::OFS_P0_IRQ_EN) |=> p0_en_q == $past(req.wdata))
      else $error("port zero enable not stored");

   chk_p1_en_upper: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_at(usb_gpio_pkg::OFS_P1_IRQ_EN)
      |=> p1_en_q[7:2] == 6'h00 && p1_en_q[1:0] == $past(req.wdata[1:0]))
      else $error("port one enable wrong");

   chk_p0_pol_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !wr_at(usb_gpio_pkg::OFS_P0_IRQ_POL) |=> $stable(p0_pol_q))
      else $error("port zero polarity changed without write");

   chk_p1_pol_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_at(usb_gpio_pkg::OFS_P1_IRQ_POL) |=> p1_pol_q == ($past(req.wdata) & 8'h03))
      else $error("port one polarity wrong");

   chk_bus_reserved: assert property (@(posedge ref_clk) disable iff (!rst_b)
      bus_activity_evt |=> bus_ctrl_q[3] && !bus_ctrl_q[4])
      else $error("bus activity flag or reserved bit wrong");

   chk_proc_pending: assert property (@(posedge ref_clk) disable iff (!rst_b)
      req.rd && req.addr == usb_gpio_pkg::OFS_PROC_STAT
      |=> rdata_q[7] == $past(irq) && rdata_q[1] == 1'b0)
      else $error("processor status read wrong");

   chk_wdog_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
      watchdog_evt |=> proc_q[6])
      else $error("watchdog flag not set");

   chk_wo_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      req.rd && req.addr >= 8'h04 && req.addr <= 8'h07 |=> rdata_q == 8'h00)
      else $error("write-only register read nonzero");

   chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !req.rd |=> rdata_q == 8'h00)
      else $error("read data outside read cycle");

   cov_pin_event: cover property (@(posedge ref_clk) disable iff (!rst_b)
      |pin_hit ##1 irq);
   cov_clear_irq: cover property (@(posedge ref_clk) disable iff (!rst_b)
      irq ##1 wr_at(usb_gpio_pkg::OFS_EVT_STATUS) ##1 !irq);
   cov_timer_tick: cover property (@(posedge ref_clk) disable iff (!rst_b)
      tick128 ##1 evt_status_q[2]);

endmodule : usb_gpio_register_map

/* tb/usb_gpio_register_map_tb_top.sv */
`timescale 1ns/10ps
module usb_gpio_register_map_tb_top;
   logic                   ref_clk;
   logic                   rst_b;
   usb_gpio_pkg::reg_req_t req;
   logic [7:0]             rdata_q;
   usb_gpio_pkg::pin_in_t  pins;
   usb_gpio_pkg::pin_cfg_t pin_cfg;
   logic [7:0]             dev_addr_q;
   logic [7:0]             bus_ctrl_q;
   logic [7:0]             clock_setup_q;
   logic [7:0]             global_en_q;
   logic [7:0]             pipe_en_q;
   logic                   bus_activity_evt;
   logic                   watchdog_evt;
   logic                   supply_drop_reset_evt;
   logic                   bus_irq_evt;
   logic                   irq_enable_sense;
   logic                   suspend;
   logic                   run;
   logic                   irq;
   int                     error_cnt;
   int                     total_checks;
   int                     cyc_cnt;
   logic [7:0]             rd_val;
   logic [7:0]             wo_ofs [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D};

   usb_gpio_register_map usb_gpio_register_map_inst (
      .ref_clk               (ref_clk),
      .rst_b                 (rst_b),
      .req                   (req),
      .rdata_q               (rdata_q),
      .pins                  (pins),
      .pin_cfg               (pin_cfg),
      .dev_addr_q            (dev_addr_q),
      .bus_ctrl_q            (bus_ctrl_q),
      .bus_activity_evt      (bus_activity_evt),
      .watchdog_evt          (watchdog_evt),
      .supply_drop_reset_evt (supply_drop_reset_evt),
      .bus_irq_evt           (bus_irq_evt),
      .irq_enable_sense      (irq_enable_sense),
      .clock_setup_q         (clock_setup_q),
      .global_en_q           (global_en_q),
      .pipe_en_q             (pipe_en_q),
      .suspend               (suspend),
      .run                   (run),
      .irq                   (irq)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // Whole sequence needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge ref_clk);
      req.wr    <= 1'b0;
      #1;
   endtask : reg_wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge ref_clk);
      req.rd   <= 1'b0;
      #1;
      check(rdata_q, exp);
   endtask : rd_chk

   // Covers two sync flops plus the edge detector with margin
   task automatic settle;
      repeat (6) @(posedge ref_clk);
      #1;
   endtask : settle

   initial begin
      rst_b                 = 1'b0;
      req                   = '0;
      pins                  = '0;
      bus_activity_evt      = 1'b0;
      watchdog_evt          = 1'b0;
      supply_drop_reset_evt = 1'b0;
      bus_irq_evt           = 1'b0;
      irq_enable_sense      = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd_chk(usb_gpio_pkg::OFS_PROC_STAT, 8'h01);
      rd_chk(usb_gpio_pkg::OFS_BUS_STAT, 8'h00);
      check({6'h00, suspend, run}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         reg_wr(wo_ofs[i], 8'hFF);
         rd_chk(wo_ofs[i], 8'h00);
      end
      check({6'h00, pin_cfg.p1_mode_lo}, 8'h03);
      $display("test reset_and_write_only done");

      reg_wr(usb_gpio_pkg::OFS_P0_IRQ_EN, 8'h01);
      reg_wr(usb_gpio_pkg::OFS_P0_IRQ_POL, 8'h01);
      reg_wr(usb_gpio_pkg::OFS_EVT_MASK, 8'h00);
      @(posedge ref_clk);
      pins.p0 <= 8'h03;
      settle();
      rd_chk(usb_gpio_pkg::OFS_EVT_STATUS, 8'h01);
      check({7'h00, irq}, 8'h00);
      reg_wr(usb_gpio_pkg::OFS_EVT_MASK, 8'h01);
      check({7'h00, irq}, 8'h01);
      reg_wr(usb_gpio_pkg::OFS_EVT_STATUS, 8'h01);
      check({7'h00, irq}, 8'h00);
      reg_wr(usb_gpio_pkg::OFS_P0_IRQ_POL, 8'h00);
      @(posedge ref_clk);
      pins.p0 <= 8'h03;
      settle();
      rd_chk(usb_gpio_pkg::OFS_EVT_STATUS, 8'h00);
      @(posedge ref_clk);
      pins.p0 <= 8'h00;
      settle();
      rd_chk(usb_gpio_pkg::OFS_EVT_STATUS, 8'h01);
      reg_wr(usb_gpio_pkg::OFS_EVT_STATUS, 8'h1F);
      $display("test port_zero_events done");

      reg_wr(usb_gpio_pkg::OFS_P1_IRQ_EN, 8'hFE);
      reg_wr(usb_gpio_pkg::OFS_P1_IRQ_POL, 8'h02);
      @(posedge ref_clk);
      pins.p1 <= 2'b11;
      settle();
      rd_chk(usb_gpio_pkg::OFS_EVT_STATUS, 8'h02);
      reg_wr(usb_gpio_pkg::OFS_EVT_STATUS, 8'h1F);
      reg_wr(usb_gpio_pkg::OFS_P1_IRQ_POL, 8'hFC);
      @(posedge ref_clk);
      pins.p1 <= 2'b00;
      settle();
      rd_chk(usb_gpio_pkg::OFS_EVT_STATUS, 8'h02);
      reg_wr(usb_gpio_pkg::OFS_EVT_STATUS, 8'h1F);
      reg_wr(usb_gpio_pkg::OFS_EVT_MASK, 8'h00);
      $display("test port_one_events done");

      reg_wr(usb_gpio_pkg::OFS_BUS_STAT, 8'hFF);
      rd_chk(usb_gpio_pkg::OFS_BUS_STAT, 8'hEF);
      check(bus_ctrl_q, 8'hEF);
      reg_wr(usb_gpio_pkg::OFS_BUS_STAT, 8'h00);
      @(posedge ref_clk);
      bus_activity_evt <= 1'b1;
      @(posedge ref_clk);
      bus_activity_evt <= 1'b0;
      settle();
      rd_chk(usb_gpio_pkg::OFS_BUS_STAT, 8'h08);
      $display("test bus_status done");

      irq_enable_sense <= 1'b1;
      reg_wr(usb_gpio_pkg::OFS_PROC_STAT, 8'hFF);
      rd_chk(usb_gpio_pkg::OFS_PROC_STAT, 8'h7D);
      check({6'h00, suspend, run}, 8'h03);
      reg_wr(usb_gpio_pkg::OFS_PROC_STAT, 8'h00);
      rd_chk(usb_gpio_pkg::OFS_PROC_STAT, 8'h04);
      check({6'h00, suspend, run}, 8'h00);
      @(posedge ref_clk);
      watchdog_evt          <= 1'b1;
      supply_drop_reset_evt <= 1'b1;
      bus_irq_evt           <= 1'b1;
      @(posedge ref_clk);
      watchdog_evt          <= 1'b0;
      supply_drop_reset_evt <= 1'b0;
      bus_irq_evt           <= 1'b0;
      settle();
      rd_chk(usb_gpio_pkg::OFS_PROC_STAT, 8'h74);
      reg_wr(usb_gpio_pkg::OFS_EVT_MASK, 8'h10);
      rd_chk(usb_gpio_pkg::OFS_PROC_STAT, 8'hF4);
      $display("test processor_status done");

      reg_wr(usb_gpio_pkg::OFS_PIPE_EN, 8'hFF);
      rd_chk(usb_gpio_pkg::OFS_PIPE_EN, 8'h03);
      reg_wr(usb_gpio_pkg::OFS_GLOBAL_EN, 8'hFF);
      rd_chk(usb_gpio_pkg::OFS_GLOBAL_EN, 8'hC7);
      reg_wr(8'h03, 8'hFF);
      rd_chk(8'h03, 8'h00);
      reg_wr(usb_gpio_pkg::OFS_TIMER_HI, 8'hFF);
      rd_chk(usb_gpio_pkg::OFS_TIMER_HI, 8'h00);
      @(posedge ref_clk);
      pins.p2                  <= 3'h7;
      pins.dplus               <= 1'b1;
      pins.serial_program_data <= 1'b1;
      settle();
      rd_chk(usb_gpio_pkg::OFS_P2_STATE, 8'h37);
      $display("test reserved_bits done");
      final_report();
   end
endmodule : usb_gpio_register_map_tb_top
